//--- src/nand_block_protect_ecc.sv
// block lock decode, lock-down and per-page ecc of a serial nand
// Summary of operation
// [R1] power-up: level 111, invert/complement/write-disable zero
// [R2] write-disable with pin low freezes lock bits
// [R3] locked program/erase never starts, busy stays 0
// [R4] erase of locked block sets erase fail
// [R5] program of locked block sets program fail
// [R6] write-protect pin ignored while quad select set
// [R7] level 000 locks nothing, 111 locks all
// [R8] plain levels lock upper fraction of rows
// [R9] invert alone locks lower fraction of rows
// [R10] complement alone locks lower rest, 110 block0
// [R11] both set lock upper rest, 110 block0
// [R12] host changes protection via feature a0
// [R13] lock-down bit freezes all protection bits
// [R14] lock-down cleared only by power cycle
// [R15] ecc enable resets to 1, host writable
// [R16] program computes parity over cached page
// [R17] read checks parity, corrects cache, outputs fixed
// [R18] every read reports correction outcome
// [R19] four 512 byte main segments, own parity
// [R20] spare: four bytes unprotected, twelve protected
// [R21] ecc on: parity area writes dropped, readable
// [R22] ecc off: whole page raw, both ways
// [R23] host reads bad block mark ecc off
// [R24] status 00 clean, 01 fixed, 10 failed
// [R25] locked check compares target row with range
`timescale 1ns/100ps
module nand_block_protect_ecc (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic wp_n,
  output logic [nand_prot_pkg::ROW_W-1:0] arr_row,
  output logic [nand_prot_pkg::COL_W-1:0] arr_col,
  output logic arr_wr,
  output logic [7:0] arr_wdata,
  output logic arr_erase,
  input wire logic [7:0] arr_rdata,
  output logic operation_in_progress,
  output logic program_fail,
  output logic erase_fail,
  output logic [1:0] correction_status,
  output logic ecc_enable
);
  import nand_prot_pkg::*;

  function automatic logic row_locked(input logic [7:0] lk,
                                      input logic [15:0] row);
    logic [2:0] lvl;
    logic [16:0] span, lo, hi;
    lvl = lk[LOCK_LVL_LSB +: 3];
    span = ROW_SPAN >> (5'h10 - 5'(lvl + ROW_SHIFT_BASE));
    case ({lk[LOCK_CMP_BIT], lk[LOCK_INV_BIT]})
      2'b00: begin lo = ROW_SPAN - span; hi = ROW_SPAN - 17'h1; end // [R8]
      2'b01: begin lo = 17'h0; hi = span - 17'h1; end // [R9]
      2'b10: begin lo = 17'h0; hi = ROW_SPAN - 17'h1 - span; end // [R10]
      default: begin lo = span; hi = ROW_SPAN - 17'h1; end // [R11]
    endcase
    if (lk[LOCK_CMP_BIT] && lvl == LVL_HALF)
    begin
      lo = 17'h0; // [R10] [R11]
      hi = BLOCK0_LAST;
    end
    if (lvl == LVL_NONE)
      return 1'b0; // [R7]
    if (lvl == LVL_ALL)
      return 1'b1; // [R7]
    return ({1'b0, row} >= lo) && ({1'b0, row} <= hi);
  endfunction : row_locked

  // {protected, segment, index inside the segment}
  function automatic logic [12:0] seg_map(input logic [11:0] a);
    logic [11:0] off;
    off = a - SPARE_BASE;
    if (a < SPARE_BASE)
      return {1'b1, a[10:9], 1'b0, a[8:0]}; // [R19]
    if (a < PARITY_BASE)
      return {off[3:0] >= META_FREE_BYTES, off[5:4], // [R20]
              SEG_MAIN_BYTES + 10'(off[3:0] - META_FREE_BYTES)};
    return 13'h0000;
  endfunction : seg_map

  function automatic logic [11:0] seg_addr(input logic [1:0] s,
                                           input logic [9:0] loc);
    if (loc < SEG_MAIN_BYTES)
      return {1'b0, s, loc[8:0]};
    return SPARE_BASE + {6'h00, s, 4'h0} + {8'h00, META_FREE_BYTES}
           + 12'(loc - SEG_MAIN_BYTES);
  endfunction : seg_addr

  // single-error code: xor of bit positions plus overall parity
  function automatic logic [13:0] ecc_contrib(input logic [9:0] loc,
                                              input logic [7:0] d);
    logic [12:0] code;
    code = 13'h0000;
    for (int b = 0; b < 8; b++)
      if (d[b])
        code = code ^ ({loc, 3'(b)} + 13'h0001);
    return {^d, code};
  endfunction : ecc_contrib

  function automatic logic is_parity(input logic [11:0] a);
    return (a >= PARITY_BASE) && (a < PAGE_BYTES);
  endfunction : is_parity

  logic rst_s1_r, rst_i_n;
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_i_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_i_n <= rst_s1_r;
    end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_i_n);

  logic [7:0] rx_byte, tx_r, tx_nxt;
  logic rx_toggle;
  spi_link u_link (
    .link_sck(link_sck),
    .cs_n(cs_n),
    .rst_i_n(rst_i_n),
    .mosi(mosi),
    .tx_byte(tx_r),
    .miso(miso),
    .miso_oe(miso_oe),
    .rx_byte(rx_byte),
    .rx_toggle(rx_toggle)
  );

  // select takes one stage more, so frame end trails its last byte
  logic cs_s1_r, cs_s2_r, cs_d1_r, cs_d2_r;
  logic tg_s1_r, tg_s2_r, tg_d_r, wp_s1_r, wp_s2_r;
  always_ff @(posedge sys_clk or negedge rst_i_n)
    if (!rst_i_n)
    begin
      {cs_s1_r, cs_s2_r, cs_d1_r, cs_d2_r} <= 4'hf;
      {tg_s1_r, tg_s2_r, tg_d_r} <= 3'h0;
      {wp_s1_r, wp_s2_r} <= 2'h3;
    end
    else
    begin
      {cs_s1_r, cs_s2_r, cs_d1_r, cs_d2_r} <= {cs_n, cs_s1_r, cs_s2_r,
                                                cs_d1_r};
      {tg_s1_r, tg_s2_r, tg_d_r} <= {rx_toggle, tg_s1_r, tg_s2_r};
      {wp_s1_r, wp_s2_r} <= {wp_n, wp_s1_r};
    end

  logic rx_evt, frame_end;
  assign rx_evt = tg_s2_r ^ tg_d_r;
  assign frame_end = cs_d1_r & ~cs_d2_r;

  op_state_t op_r, op_nxt;
  logic [7:0] lock_r, lock_nxt, cfg_r, cfg_nxt, opc_r, opc_nxt;
  logic [7:0] a1_r, a1_nxt, wdata_r, wdata_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [11:0] col_r, col_nxt, idx_r, idx_nxt, addr_r, addr_nxt;
  logic [15:0] row_r, row_nxt, op_row_r, op_row_nxt;
  logic efail_r, efail_nxt, pfail_r, pfail_nxt;
  logic [1:0] eccst_r, eccst_nxt, seg_r, seg_nxt;
  logic wr_r, wr_nxt, rdv_r, rdv_nxt, erase_r, erase_nxt;
  logic [13:0] acc_r [4];
  logic [13:0] acc_nxt [4];
  logic [7:0] cache_r [PAGE_BYTES];
  logic cwe;
  logic [11:0] cwa, pb;
  logic [7:0] cwd, st;
  logic [13:0] syn;
  logic [12:0] pos, m_idx, m_rd;
  logic ecc_en, wp_active, lock_wr_ok, target_locked, cmd_ok;

  assign ecc_en = cfg_r[CFG_ECC_BIT];
  // the pin only counts while quad select is clear
  assign wp_active = ~cfg_r[CFG_QE_BIT] & ~wp_s2_r; // [R6]
  assign lock_wr_ok = ~cfg_r[CFG_LD_BIT] // [R13]
                      & ~(lock_r[LOCK_PWD_BIT] & wp_active); // [R2]
  assign target_locked = row_locked(lock_r, row_r); // [R25]
  assign cmd_ok = frame_end & (cnt_r == CNT_FULL) & (op_r == OP_IDLE);
  assign m_idx = seg_map(idx_r);
  assign m_rd = seg_map(addr_r);
  assign pb = PARITY_BASE + {6'h00, seg_r, 4'h0};
  assign syn = acc_r[seg_r] ^ {cache_r[pb + 12'h1][5:0], cache_r[pb]};
  assign pos = syn[12:0] - 13'h0001;

  always_comb
  begin
    st = 8'h00;
    st[STAT_OIP_BIT] = operation_in_progress;
    st[STAT_EFAIL_BIT] = efail_r;
    st[STAT_PFAIL_BIT] = pfail_r;
    st[STAT_ECC_LSB +: 2] = eccst_r;
  end

  always_comb
  begin
    op_nxt = op_r;
    lock_nxt = lock_r;
    cfg_nxt = cfg_r;
    opc_nxt = opc_r;
    a1_nxt = a1_r;
    cnt_nxt = cnt_r;
    col_nxt = col_r;
    row_nxt = row_r;
    op_row_nxt = op_row_r;
    tx_nxt = tx_r;
    efail_nxt = efail_r;
    pfail_nxt = pfail_r;
    eccst_nxt = eccst_r;
    seg_nxt = seg_r;
    idx_nxt = idx_r;
    acc_nxt = acc_r;
    addr_nxt = addr_r;
    wdata_nxt = 8'hff;
    wr_nxt = 1'b0;
    rdv_nxt = 1'b0;
    erase_nxt = 1'b0;
    cwe = 1'b0;
    cwa = col_r;
    cwd = rx_byte;
    if (rx_evt)
    begin
      if (cnt_r != CNT_FULL)
        cnt_nxt = cnt_r + 3'h1;
      if (cnt_r == 3'h0)
        opc_nxt = rx_byte;
      if (cnt_r == 3'h1)
        a1_nxt = rx_byte;
      if (cnt_r == 3'h2 || cnt_r == 3'h3)
        row_nxt = {row_r[7:0], rx_byte};
      if (cnt_r == 3'h1 && opc_r == OPC_GET_FEAT)
        tx_nxt = (rx_byte == FEAT_LOCK) ? lock_r
               : (rx_byte == FEAT_CFG) ? cfg_r
               : (rx_byte == FEAT_STATUS) ? st : 8'h00;
      if (cnt_r == 3'h2 && opc_r == OPC_SET_FEAT)
      begin
        if (a1_r == FEAT_LOCK && lock_wr_ok)
          lock_nxt = rx_byte & LOCK_WMASK; // [R2] [R13]
        if (a1_r == FEAT_CFG)
          cfg_nxt = (rx_byte & CFG_WMASK) // [R14] [R15]
                    | (cfg_r & CFG_LD_MASK);
      end
      if (cnt_r == 3'h2 && (opc_r == OPC_PROG_LOAD
                            || opc_r == OPC_READ_CACHE))
        col_nxt = {a1_r[3:0], rx_byte};
      if (cnt_r >= 3'h3 && opc_r == OPC_PROG_LOAD && op_r == OP_IDLE)
      begin
        // with ecc off every byte inside the page lands, parity area included
        cwe = (col_r < PAGE_BYTES) // [R21] [R22]
              & ~(ecc_en & is_parity(col_r));
        col_nxt = col_r + 12'h1;
      end
      if (cnt_r >= 3'h3 && opc_r == OPC_READ_CACHE)
      begin
        tx_nxt = (col_r < PAGE_BYTES) ? cache_r[col_r] : 8'hff; // [R17] [R21]
        col_nxt = col_r + 12'h1;
      end
    end
    if (frame_end)
      cnt_nxt = 3'h0;
    case (op_r)
      OP_IDLE:
        if (cmd_ok)
        begin
          idx_nxt = 12'h000;
          op_row_nxt = row_r;
          for (int s = 0; s < 4; s++)
            acc_nxt[s] = 14'h0000;
          if (opc_r == OPC_ERASE)
          begin
            if (target_locked)
              efail_nxt = 1'b1; // [R3] [R4]
            else
            begin
              efail_nxt = 1'b0;
              erase_nxt = 1'b1;
              op_nxt = OP_ERASE;
            end
          end
          if (opc_r == OPC_PROG_EXEC)
          begin
            if (target_locked)
              pfail_nxt = 1'b1; // [R3] [R5]
            else
            begin
              pfail_nxt = 1'b0;
              op_nxt = OP_PROG;
            end
          end
          if (opc_r == OPC_PAGE_READ)
          begin
            eccst_nxt = ECC_OK;
            op_nxt = OP_READ;
          end
        end
      OP_ERASE:
        op_nxt = OP_IDLE;
      OP_PROG:
        if (idx_r == PAGE_BYTES)
          op_nxt = OP_IDLE;
        else
        begin
          addr_nxt = idx_r;
          wr_nxt = 1'b1;
          wdata_nxt = cache_r[idx_r];
          if (ecc_en && is_parity(idx_r))
            wdata_nxt = (idx_r[3:0] == 4'h0) ? acc_r[idx_r[5:4]][7:0] // [R16]
                      : (idx_r[3:0] == 4'h1) ? {2'h0, acc_r[idx_r[5:4]][13:8]}
                      : 8'hff;
          if (ecc_en && m_idx[12])
            acc_nxt[m_idx[11:10]] = acc_r[m_idx[11:10]] // [R16]
                                    ^ ecc_contrib(m_idx[9:0], cache_r[idx_r]);
          idx_nxt = idx_r + 12'h1;
        end
      OP_READ:
      begin
        if (idx_r != PAGE_BYTES)
        begin
          addr_nxt = idx_r;
          rdv_nxt = 1'b1;
          idx_nxt = idx_r + 12'h1;
        end
        if (rdv_r)
        begin
          cwe = 1'b1;
          cwa = addr_r;
          cwd = arr_rdata;
          if (ecc_en && m_rd[12])
            acc_nxt[m_rd[11:10]] = acc_r[m_rd[11:10]] // [R17]
                                   ^ ecc_contrib(m_rd[9:0], arr_rdata);
        end
        if (idx_r == PAGE_BYTES && !rdv_r)
        begin
          seg_nxt = 2'h0;
          op_nxt = ecc_en ? OP_CORR : OP_IDLE; // [R22]
        end
      end
      OP_CORR:
      begin
        // odd parity: one flipped bit, fixed in place in the cache unless it is the overall parity bit (syndrome zero) or its position lies past the segment
        if (syn[13])
        begin
          if (syn[12:0] != 13'h0000 && pos[12:3] >= SEG_LOCAL_BYTES)
            eccst_nxt = ECC_FAIL; // [R24]
          else
          begin
            if (syn[12:0] != 13'h0000)
            begin
              cwe = 1'b1; // [R17]
              cwa = seg_addr(seg_r, pos[12:3]);
              cwd = cache_r[cwa] ^ (8'h01 << pos[2:0]);
            end
            if (eccst_r != ECC_FAIL)
              eccst_nxt = ECC_FIXED; // [R18] [R24]
          end
        end
        else if (syn[12:0] != 13'h0000)
          eccst_nxt = ECC_FAIL; // [R18] [R24]
        seg_nxt = seg_r + 2'h1;
        if (seg_r == 2'h3)
          op_nxt = OP_IDLE;
      end
      default:
        op_nxt = OP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_i_n)
    if (!rst_i_n)
    begin
      op_r <= OP_IDLE;
      lock_r <= LOCK_RESET; // [R1]
      cfg_r <= CFG_RESET; // [R14] [R15]
      opc_r <= 8'h00;
      a1_r <= 8'h00;
      cnt_r <= 3'h0;
      col_r <= 12'h000;
      row_r <= 16'h0000;
      op_row_r <= 16'h0000;
      tx_r <= 8'hff;
      efail_r <= 1'b0;
      pfail_r <= 1'b0;
      eccst_r <= ECC_OK;
      seg_r <= 2'h0;
      idx_r <= 12'h000;
      addr_r <= 12'h000;
      wdata_r <= 8'hff;
      wr_r <= 1'b0;
      rdv_r <= 1'b0;
      erase_r <= 1'b0;
      for (int s = 0; s < 4; s++)
        acc_r[s] <= 14'h0000;
    end
    else
    begin
      op_r <= op_nxt;
      lock_r <= lock_nxt;
      cfg_r <= cfg_nxt;
      opc_r <= opc_nxt;
      a1_r <= a1_nxt;
      cnt_r <= cnt_nxt;
      col_r <= col_nxt;
      row_r <= row_nxt;
      op_row_r <= op_row_nxt;
      tx_r <= tx_nxt;
      efail_r <= efail_nxt;
      pfail_r <= pfail_nxt;
      eccst_r <= eccst_nxt;
      seg_r <= seg_nxt;
      idx_r <= idx_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      wr_r <= wr_nxt;
      rdv_r <= rdv_nxt;
      erase_r <= erase_nxt;
      acc_r <= acc_nxt;
    end

  // page cache holds no reset: contents are undefined until loaded
  always_ff @(posedge sys_clk)
    if (cwe)
      cache_r[cwa] <= cwd;

  assign arr_row = op_row_r;
  assign arr_col = addr_r;
  assign arr_wr = wr_r;
  assign arr_wdata = wdata_r;
  assign arr_erase = erase_r;
  assign operation_in_progress = (op_r != OP_IDLE);
  assign program_fail = pfail_r;
  assign erase_fail = efail_r;
  assign correction_status = eccst_r;
  assign ecc_enable = ecc_en;

  a_reset_locked: assert property ($rose(rst_i_n) |-> // [R1]
    lock_r == LOCK_RESET && cfg_r == CFG_RESET)
    else $error("protection not locked after reset");
  a_pwd_hold: assert property (rx_evt && cnt_r == 3'h2 // [R2]
    && opc_r == OPC_SET_FEAT && a1_r == FEAT_LOCK
    && lock_r[LOCK_PWD_BIT] && wp_active |=> $stable(lock_r))
    else $error("lock bits changed under write protect");
  a_qe_frees_pin: assert property (rx_evt && cnt_r == 3'h2 // [R6]
    && opc_r == OPC_SET_FEAT && a1_r == FEAT_LOCK
    && cfg_r[CFG_QE_BIT] && !cfg_r[CFG_LD_BIT]
    |=> lock_r == ($past(rx_byte) & LOCK_WMASK))
    else $error("lock write refused with quad select set");
  a_locked_idle: assert property (cmd_ok && target_locked // [R3]
    && (opc_r == OPC_ERASE || opc_r == OPC_PROG_EXEC)
    |=> (!operation_in_progress && !arr_wr && !arr_erase) [*3])
    else $error("locked operation started");
  a_erase_fail: assert property (cmd_ok && target_locked // [R4]
    && opc_r == OPC_ERASE |=> erase_fail)
    else $error("erase fail not set");
  a_prog_fail: assert property (cmd_ok && target_locked // [R5]
    && opc_r == OPC_PROG_EXEC |=> program_fail ##1 !arr_wr)
    else $error("program fail not set");
  a_full_range: assert property (lock_r[LOCK_LVL_LSB +: 3] == LVL_ALL // [R7]
    |-> target_locked)
    else $error("level 111 left a row open");
  a_lockdown_freeze: assert property (cfg_r[CFG_LD_BIT] // [R13]
    |=> $stable(lock_r))
    else $error("lock bits changed under lock-down");
  a_lockdown_kept: assert property (cfg_r[CFG_LD_BIT] // [R14]
    |=> cfg_r[CFG_LD_BIT])
    else $error("lock-down cleared");
  a_parity_discard: assert property (cwe && op_r == OP_IDLE // [R21]
    && ecc_en |-> !is_parity(cwa))
    else $error("parity byte written with ecc on");
  a_status_code: assert property (correction_status != 2'h3) // [R24]
    else $error("reserved correction code");
  a_corr_done: assert property (op_r == OP_CORR && seg_r == 2'h0 // [R18]
    |-> ##4 op_r == OP_IDLE)
    else $error("correction pass not four segments");
endmodule : nand_block_protect_ecc

//--- src/nand_prot_pkg.sv
// constants shared by the block protection and page ecc logic
package nand_prot_pkg;
  localparam int COL_W = 12;
  localparam int ROW_W = 16;
  localparam logic [11:0] PAGE_BYTES = 12'h880;
  localparam logic [11:0] SPARE_BASE = 12'h800;
  localparam logic [11:0] PARITY_BASE = 12'h840;
  localparam logic [9:0] SEG_MAIN_BYTES = 10'h200;
  localparam logic [9:0] SEG_LOCAL_BYTES = 10'h20c;
  localparam logic [3:0] META_FREE_BYTES = 4'h4;
  localparam logic [7:0] OPC_SET_FEAT = 8'h1f;
  localparam logic [7:0] OPC_GET_FEAT = 8'h0f;
  localparam logic [7:0] OPC_PROG_LOAD = 8'h02;
  localparam logic [7:0] OPC_PROG_EXEC = 8'h10;
  localparam logic [7:0] OPC_ERASE = 8'hd8;
  localparam logic [7:0] OPC_PAGE_READ = 8'h13;
  localparam logic [7:0] OPC_READ_CACHE = 8'h03;
  localparam logic [7:0] FEAT_LOCK = 8'ha0;
  localparam logic [7:0] FEAT_CFG = 8'hb0;
  localparam logic [7:0] FEAT_STATUS = 8'hc0;
  localparam int LOCK_PWD_BIT = 7;
  localparam int LOCK_LVL_LSB = 3;
  localparam int LOCK_INV_BIT = 2;
  localparam int LOCK_CMP_BIT = 1;
  localparam logic [7:0] LOCK_RESET = 8'h38;
  localparam logic [7:0] LOCK_WMASK = 8'hbe;
  localparam int CFG_QE_BIT = 0;
  localparam int CFG_LD_BIT = 2;
  localparam int CFG_ECC_BIT = 4;
  localparam logic [7:0] CFG_RESET = 8'h10;
  localparam logic [7:0] CFG_WMASK = 8'h15;
  localparam logic [7:0] CFG_LD_MASK = 8'h04;
  localparam int STAT_OIP_BIT = 0;
  localparam int STAT_EFAIL_BIT = 2;
  localparam int STAT_PFAIL_BIT = 3;
  localparam int STAT_ECC_LSB = 4;
  localparam logic [3:0] ROW_SHIFT_BASE = 4'h9;
  localparam logic [16:0] ROW_SPAN = 17'h10000;
  localparam logic [16:0] BLOCK0_LAST = 17'h0003f;
  localparam logic [2:0] LVL_NONE = 3'h0;
  localparam logic [2:0] LVL_HALF = 3'h6;
  localparam logic [2:0] LVL_ALL = 3'h7;
  localparam logic [2:0] CNT_FULL = 3'h4;
  localparam logic [1:0] ECC_OK = 2'h0;
  localparam logic [1:0] ECC_FIXED = 2'h1;
  localparam logic [1:0] ECC_FAIL = 2'h2;
  typedef enum {OP_IDLE, OP_ERASE, OP_PROG, OP_READ, OP_CORR} op_state_t;
endpackage : nand_prot_pkg

//--- src/spi_link.sv
// serial byte shifter running on the link clock
`timescale 1ns/100ps
module spi_link (
  input wire logic link_sck,
  input wire logic cs_n,
  input wire logic rst_i_n,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic miso_oe,
  output logic [7:0] rx_byte,
  output logic rx_toggle
);
  logic [2:0] bit_r, bit_nxt;
  logic [6:0] sh_r, sh_nxt;
  logic [7:0] rx_r, rx_nxt, tx_r, tx_nxt;
  logic tg_r, tg_nxt;

  always_comb
  begin
    bit_nxt = bit_r + 3'h1;
    sh_nxt = {sh_r[5:0], mosi};
    rx_nxt = rx_r;
    tg_nxt = tg_r;
    if (bit_r == 3'h7)
    begin
      rx_nxt = {sh_r, mosi};
      tg_nxt = ~tg_r;
    end
    // reply byte is sampled a half bit after the byte boundary
    tx_nxt = (bit_r == 3'h0) ? tx_byte : {tx_r[6:0], 1'b1};
  end

  // chip select high parks the bit counter between frames
  always_ff @(posedge link_sck or posedge cs_n)
    if (cs_n)
      bit_r <= 3'h0;
    else
      bit_r <= bit_nxt;

  // toggle is never cleared by select, so no event is lost
  always_ff @(posedge link_sck or negedge rst_i_n)
    if (!rst_i_n)
    begin
      sh_r <= 7'h00;
      rx_r <= 8'h00;
      tg_r <= 1'b0;
    end
    else
    begin
      sh_r <= sh_nxt;
      rx_r <= rx_nxt;
      tg_r <= tg_nxt;
    end

  always_ff @(negedge link_sck or negedge rst_i_n)
    if (!rst_i_n)
      tx_r <= 8'hff;
    else
      tx_r <= tx_nxt;

  assign miso = tx_r[7];
  assign miso_oe = ~cs_n;
  assign rx_byte = rx_r;
  assign rx_toggle = tg_r;
endmodule : spi_link

//--- tb/host_spi.sv
// host side serial controller model issuing feature and array commands
`timescale 1ns/100ps
module host_spi (
  output logic link_sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial
  begin
    link_sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // sends n bytes msb first from the top of w; r ends as last byte in
  task automatic xfer(input int n, input logic [39:0] w,
                      output logic [7:0] r);
    #3;
    cs_n = 1'b0;
    for (int i = 0; i < n * 8; i++)
    begin
      mosi = w[39 - i];
      #40 link_sck = 1'b1;
      r = {r[6:0], miso};
      #40 link_sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    // released line must not keep showing stale data
    mosi = ~mosi;
    #100;
  endtask : xfer
endmodule : host_spi

//--- tb/tb.sv
// self-checking bench for block protection and page ecc
`timescale 1ns/100ps
module tb;
  import nand_prot_pkg::*;
  logic sys_clk, rst_n, wp_n, link_sck, cs_n, mosi, miso, miso_oe;
  logic [ROW_W-1:0] arr_row;
  logic [COL_W-1:0] arr_col;
  logic arr_wr, arr_erase, operation_in_progress, program_fail, erase_fail, ecc_enable;
  logic [7:0] arr_wdata, arr_rdata, r, keep;
  logic [1:0] correction_status;
  logic [7:0] mem [0:2175];
  logic [7:0] exp_q [$];
  logic [7:0] got_q [$];
  logic [31:0] seed = 32'hbe85c968;
  logic [15:0] f;
  logic [15:0] rows [4];
  logic [11:0] fc1 [5] = '{12'h000, 12'h801, 12'h805, 12'h010, 12'h600};
  logic [11:0] fc2 [5] = '{12'hfff, 12'hfff, 12'hfff, 12'h020, 12'hfff};
  logic [1:0] fst [5] = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h1};
  logic [2:0] lv;
  logic iv, cp, ex;
  int err_count = 0, comparisons = 0, busy_cnt = 0, exp_busy = 0;
  int ers_cnt = 0, exp_ers = 0;

  host_spi i_host (.link_sck(link_sck), .cs_n(cs_n), .mosi(mosi),
    .miso(miso));
  nand_block_protect_ecc i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .link_sck(link_sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .wp_n(wp_n), .arr_row(arr_row), .arr_col(arr_col),
    .arr_wr(arr_wr), .arr_wdata(arr_wdata), .arr_erase(arr_erase),
    .arr_rdata(arr_rdata), .operation_in_progress(operation_in_progress), .program_fail(program_fail),
    .erase_fail(erase_fail), .correction_status(correction_status),
    .ecc_enable(ecc_enable));

  // array model: one page, row ignored
  assign arr_rdata = mem[arr_col];
  always @(posedge sys_clk)
    if (arr_wr === 1'b1)
      mem[arr_col] <= arr_wdata;
  always @(posedge operation_in_progress)
    busy_cnt++;
  always @(posedge sys_clk)
    if (arr_erase === 1'b1)
      ers_cnt++;

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  function automatic logic lk(input logic [2:0] l, input logic i, c,
                              input logic [15:0] row);
    logic [16:0] w, b;
    w = 17'h400 << (l - 3'h1);
    b = i ? w : 17'h10000 - w;
    if (l == 3'h0) return 1'b0;
    if (l == 3'h7) return 1'b1;
    if (c && l == 3'h6) return row <= 16'h003f;
    return (c ^ i) == ({1'b0, row} < b);
  endfunction : lk

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // monitor takes the oldest expectation whenever a result shows up
  always @(posedge sys_clk)
    while (got_q.size() > 0 && exp_q.size() > 0)
      check(got_q.pop_front(), exp_q.pop_front());

  task automatic note(input logic [7:0] seen, input logic [7:0] want);
    exp_q.push_back(want);
    got_q.push_back(seen);
  endtask : note

  task automatic wrap_up();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic wait_idle();
    int k;
    repeat (8) @(negedge sys_clk);
    k = 0;
    while (operation_in_progress !== 1'b0 && k < 5000)
    begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 5000)
    begin
      err_count++;
      wrap_up();
    end
  endtask : wait_idle

  task automatic do_reset();
    @(negedge sys_clk) rst_n = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : do_reset

  task automatic set_feat(input logic [7:0] a, input logic [7:0] d);
    i_host.xfer(3, {OPC_SET_FEAT, a, d, 16'h0}, r);
  endtask : set_feat

  task automatic rd_feat(input logic [7:0] a, input logic [7:0] want);
    i_host.xfer(3, {OPC_GET_FEAT, a, 24'h0}, r);
    note(r, want);
  endtask : rd_feat

  task automatic exec(input logic [7:0] op, input logic [15:0] row,
                      input logic locked);
    i_host.xfer(4, {op, 8'h00, row, 8'h00}, r);
    if (!locked)
      exp_busy++;
    if (!locked && op == OPC_ERASE)
      exp_ers++;
    wait_idle();
    note(arr_row[15:8], row[15:8]);
    note(arr_row[7:0], row[7:0]);
  endtask : exec

  task automatic rd_cache(input logic [11:0] col, input logic [7:0] want);
    i_host.xfer(5, {OPC_READ_CACHE, 4'h0, col, 16'h0}, r);
    note(r, want);
  endtask : rd_cache

  task automatic load(input logic [11:0] col, input logic [7:0] d);
    i_host.xfer(4, {OPC_PROG_LOAD, 4'h0, col, d, 8'h00}, r);
  endtask : load

  initial
  begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    for (int i = 0; i < 2176; i++)
    begin
      seed = xs(seed);
      mem[i] = seed[7:0];
    end
    do_reset();
    rd_feat(FEAT_LOCK, 8'h38);
    rd_feat(FEAT_CFG, 8'h10);
    exec(OPC_PROG_EXEC, 16'h1234, 1'b1);
    exec(OPC_ERASE, 16'h0000, 1'b1);
    rd_feat(FEAT_STATUS, 8'h0c);
    set_feat(FEAT_LOCK, 8'h80);
    @(negedge sys_clk) wp_n = 1'b0;
    set_feat(FEAT_LOCK, 8'h38);
    rd_feat(FEAT_LOCK, 8'h80);
    set_feat(FEAT_CFG, 8'h11);
    set_feat(FEAT_LOCK, 8'h38);
    rd_feat(FEAT_LOCK, 8'h38);
    set_feat(FEAT_CFG, 8'h10);
    @(negedge sys_clk) wp_n = 1'b1;
    for (int m = 0; m < 32; m++)
    begin
      lv = m[2:0];
      iv = m[3];
      cp = m[4];
      set_feat(FEAT_LOCK, {2'b00, lv, iv, cp, 1'b0});
      f = 16'h0400 << (lv - 3'h1);
      rows = '{f - 16'h1, 16'h0 - f, 16'h003f, 16'h0040};
      foreach (rows[k])
      begin
        ex = lk(lv, iv, cp, rows[k]);
        exec(OPC_ERASE, rows[k], ex);
        note({7'h0, erase_fail}, {7'h0, ex});
      end
    end
    set_feat(FEAT_LOCK, 8'h00);
    set_feat(FEAT_CFG, 8'h00);
    note({7'h0, ecc_enable}, 8'h00);
    exec(OPC_PAGE_READ, 16'h0005, 1'b0);
    rd_cache(12'h800, mem[12'h800]);
    rd_cache(12'h845, mem[12'h845]);
    set_feat(FEAT_CFG, 8'h10);
    load(12'h842, 8'h00);
    load(12'h801, 8'h5a);
    rd_cache(12'h842, mem[12'h842]);
    exec(OPC_PROG_EXEC, 16'h0005, 1'b0);
    note(mem[12'h842], 8'hff);
    note(mem[12'h801], 8'h5a);
    for (int s = 0; s < 5; s++)
    begin
      keep = mem[fc1[s]];
      mem[fc1[s]][0] = ~keep[0];
      if (fc2[s] != 12'hfff)
        mem[fc2[s]][0] = ~mem[fc2[s]][0];
      exec(OPC_PAGE_READ, 16'h0005, 1'b0);
      note({6'h0, correction_status}, {6'h0, fst[s]});
      if (fst[s] == 2'h1)
        rd_cache(fc1[s], keep);
      mem[fc1[s]] = keep;
      if (fc2[s] != 12'hfff)
        mem[fc2[s]][0] = ~mem[fc2[s]][0];
    end
    set_feat(FEAT_CFG, 8'h14);
    set_feat(FEAT_LOCK, 8'h38);
    rd_feat(FEAT_LOCK, 8'h00);
    set_feat(FEAT_CFG, 8'h10);
    rd_feat(FEAT_CFG, 8'h14);
    do_reset();
    rd_feat(FEAT_LOCK, 8'h38);
    rd_feat(FEAT_CFG, 8'h10);
    note(busy_cnt[7:0], exp_busy[7:0]);
    note(ers_cnt[7:0], exp_ers[7:0]);
    repeat (4) @(negedge sys_clk);
    wrap_up();
  end
endmodule : tb
